/* core/timer16_pkg.sv */
// Constants for the 16-bit timer with clear-on-match and fast PWM modes
// Summary of operation
// - Clear-on-match: mode 4 top compare_a, 12 capture
// - Clear-on-match: set top register's flag at top
// - Unbuffered top; missed top wraps via 0xffff
// - Clear-on-match action 1 toggles wave_out_a
// - Pin shows wave only with direction output
// - Mode 4 toggle period 2*N*(1+compare_a) clocks
// - Clear-on-match: overflow flag at max to zero
// - Fast PWM modes 5,6,7,14,15 count up only
// - Fast PWM top: 0xff,0x1ff,0x3ff, capture, compare_a
// - Fast PWM: clear counter cycle after top
// - Action 2 non-inverted, 3 inverted PWM output
// - Fast PWM: overflow and top flag at top
// - Fixed top masks compare writes to resolution
// - Capture top unbuffered; low value wraps first
// - Fast PWM compare buffered, loaded at top
// - Fast PWM period N*(1+top) clocks
// - Compare zero spike; compare top constant level
// - Mode 15 action 1 toggles, 50% duty
// - Compare above top never matches
// - Counter equal compare sets match flag
// - Nonzero action overrides port output value
package timer16_pkg;
    localparam logic [3:0]  MODE_CTC_A   = 4'h4;
    localparam logic [3:0]  MODE_CTC_CAP = 4'hc;
    localparam logic [3:0]  MODE_FP8     = 4'h5;
    localparam logic [3:0]  MODE_FP9     = 4'h6;
    localparam logic [3:0]  MODE_FP10    = 4'h7;
    localparam logic [3:0]  MODE_FP_CAP  = 4'he;
    localparam logic [3:0]  MODE_FP_A    = 4'hf;
    localparam logic [15:0] TOP_8BIT     = 16'h00ff;
    localparam logic [15:0] TOP_9BIT     = 16'h01ff;
    localparam logic [15:0] TOP_10BIT    = 16'h03ff;
    localparam logic [15:0] COUNT_MAX    = 16'hffff;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [1:0]  ACT_OFF      = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
    localparam logic [1:0]  ACT_NONINV   = 2'h2;
    localparam logic [1:0]  ACT_INV      = 2'h3;
    // Prescaler select codes: 0 stopped, 1..5 divide 1,8,64,256,1024
    localparam logic [2:0]  PRE_STOP     = 3'h0;
    localparam logic [2:0]  PRE_1        = 3'h1;
    localparam logic [2:0]  PRE_8        = 3'h2;
    localparam logic [2:0]  PRE_64       = 3'h3;
    localparam logic [2:0]  PRE_256      = 3'h4;
    localparam logic [2:0]  PRE_1024     = 3'h5;
    localparam int          PRE_WIDTH    = 10;
    localparam logic [9:0]  DIV8_MASK    = 10'h007;
    localparam logic [9:0]  DIV64_MASK   = 10'h03f;
    localparam logic [9:0]  DIV256_MASK  = 10'h0ff;
    localparam logic [9:0]  DIV1024_MASK = 10'h3ff;
endpackage : timer16_pkg

/* core/timer16_prescaler.sv */
// Prescaler producing one-cycle timer tick enables
`timescale 1ns/1ps
module timer16_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] clock_select,
    output logic            tick
);
    logic [9:0] div_q;
    logic       hit;

    // Free-running divider; ticks come when the low bits wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 10'h000;
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    // Select the divide ratio
    always_comb begin
        case (clock_select)
            timer16_pkg::PRE_1:    hit = 1'b1;
            timer16_pkg::PRE_8:
                hit = (div_q & timer16_pkg::DIV8_MASK)
                      == timer16_pkg::DIV8_MASK;
            timer16_pkg::PRE_64:
                hit = (div_q & timer16_pkg::DIV64_MASK)
                      == timer16_pkg::DIV64_MASK;
            timer16_pkg::PRE_256:
                hit = (div_q & timer16_pkg::DIV256_MASK)
                      == timer16_pkg::DIV256_MASK;
            timer16_pkg::PRE_1024:
                hit = div_q == timer16_pkg::DIV1024_MASK;
            default:               hit = 1'b0;
        endcase
    end

    assign tick = hit;
endmodule : timer16_prescaler

/* core/timer16_pwm.sv */
// Top of the 16-bit timer: counter, compare, flags and waveform output
`timescale 1ns/1ps
module timer16_pwm #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [2:0]       clock_select,
    input  wire logic [3:0]       waveform_mode,
    input  wire logic [1:0]       output_action_a,
    input  wire logic             compare_a_we,
    input  wire logic [WIDTH-1:0] compare_a_wdata,
    input  wire logic             capture_we,
    input  wire logic [WIDTH-1:0] capture_wdata,
    input  wire logic             pin_direction_a,
    input  wire logic             port_value_a,
    input  wire logic             match_flag_a_clr,
    input  wire logic             capture_flag_clr,
    input  wire logic             overflow_flag_clr,
    output logic [WIDTH-1:0]      timer_count,
    output logic [WIDTH-1:0]      compare_a,
    output logic [WIDTH-1:0]      capture_value,
    output logic                  match_flag_a,
    output logic                  capture_flag,
    output logic                  overflow_flag,
    output logic                  wave_out_a,
    output logic                  pin_out_a,
    output logic                  pin_oe_a
);
    typedef enum logic [1:0] {
        FAM_OTHER,
        FAM_CTC,
        FAM_FAST
    } family_t;

    logic             rst_s1_q;
    logic             rst_n;
    logic             tick;
    family_t          family;
    logic [WIDTH-1:0] top;
    logic [WIDTH-1:0] res_mask;
    logic             fixed_top;
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] cmp_q;
    logic [WIDTH-1:0] cmp_buf_q;
    logic [WIDTH-1:0] cap_q;
    logic             at_top;
    logic             at_max;
    logic             match_a;
    logic             wave_q;
    logic             match_q;
    logic             capf_q;
    logic             ovf_q;
    logic             set_match;
    logic             set_cap;
    logic             set_ovf;
    logic [WIDTH-1:0] cmp_wr;

    // All-ones count limit at the configured width
    localparam logic [WIDTH-1:0] COUNT_MAX_W = '1;

    // Reset released through two flops so release is clean on clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    timer16_prescaler u_pre (
        .clk          (clk),
        .rst_n        (rst_n),
        .clock_select (clock_select),
        .tick         (tick)
    );

    // Mode decode and top selection
    always_comb begin
        family    = FAM_OTHER;
        top       = COUNT_MAX_W;
        fixed_top = 1'b0;
        case (waveform_mode)
            timer16_pkg::MODE_CTC_A: begin
                family = FAM_CTC;
                top    = cmp_q;
            end
            timer16_pkg::MODE_CTC_CAP: begin
                family = FAM_CTC;
                top    = cap_q;
            end
            timer16_pkg::MODE_FP8: begin
                family    = FAM_FAST;
                top       = WIDTH'(timer16_pkg::TOP_8BIT);
                fixed_top = 1'b1;
            end
            timer16_pkg::MODE_FP9: begin
                family    = FAM_FAST;
                top       = WIDTH'(timer16_pkg::TOP_9BIT);
                fixed_top = 1'b1;
            end
            timer16_pkg::MODE_FP10: begin
                family    = FAM_FAST;
                top       = WIDTH'(timer16_pkg::TOP_10BIT);
                fixed_top = 1'b1;
            end
            timer16_pkg::MODE_FP_CAP: begin
                family = FAM_FAST;
                top    = cap_q;
            end
            timer16_pkg::MODE_FP_A: begin
                family = FAM_FAST;
                top    = cmp_q;
            end
            default: begin
                family = FAM_OTHER;
            end
        endcase
    end

    assign res_mask = fixed_top ? top : COUNT_MAX_W;
    // Writes are trimmed to the fixed resolution
    assign cmp_wr   = compare_a_wdata & res_mask;
    // Exact equality only: a top below the count is missed
    assign at_top   = count_q == top;
    assign at_max   = count_q == COUNT_MAX_W;
    // A compare above top is never reached by the count
    assign match_a  = count_q == cmp_q;

    // Counter: clears after top, else wraps at max
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (tick) begin
            if (family != FAM_OTHER && at_top) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Compare register: direct in clear-on-match, buffered in fast PWM
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_q     <= '0;
            cmp_buf_q <= '0;
        end else begin
            if (compare_a_we) begin
                cmp_buf_q <= cmp_wr;
            end
            if (family != FAM_FAST && compare_a_we) begin
                cmp_q <= cmp_wr;
            end else if (family == FAM_FAST && tick && at_top) begin
                cmp_q <= compare_a_we ? cmp_wr : cmp_buf_q;
            end
        end
    end

    // Capture value is never buffered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q <= '0;
        end else if (capture_we) begin
            cap_q <= capture_wdata;
        end
    end

    // Flag set conditions
    assign set_match = tick && match_a;
    assign set_cap   = tick && at_top && family != FAM_OTHER
                       && (waveform_mode == timer16_pkg::MODE_CTC_CAP
                           || waveform_mode == timer16_pkg::MODE_FP_CAP);
    assign set_ovf   = tick && ((family == FAM_FAST && at_top)
                       || (family != FAM_FAST && at_max));

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
            capf_q  <= 1'b0;
            ovf_q   <= 1'b0;
        end else begin
            match_q <= set_match | (match_q & ~match_flag_a_clr);
            capf_q  <= set_cap | (capf_q & ~capture_flag_clr);
            ovf_q   <= set_ovf | (ovf_q & ~overflow_flag_clr);
        end
    end

    // Waveform register; in fast PWM the match wins over top, so a
    // compare equal to top holds a constant level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
        end else if (tick) begin
            if (family == FAM_CTC) begin
                if (match_a && output_action_a == timer16_pkg::ACT_TOGGLE)
                begin
                    wave_q <= ~wave_q;
                end
            end else if (family == FAM_FAST) begin
                if (output_action_a == timer16_pkg::ACT_TOGGLE) begin
                    if (match_a && waveform_mode == timer16_pkg::MODE_FP_A)
                    begin
                        wave_q <= ~wave_q;
                    end
                end else if (output_action_a[1]) begin
                    if (match_a) begin
                        wave_q <= output_action_a == timer16_pkg::ACT_NONINV;
                    end else if (at_top) begin
                        wave_q <= output_action_a == timer16_pkg::ACT_INV;
                    end
                end
            end
        end
    end

    // Pin mux: wave overrides the port value, direction stays software's
    assign pin_out_a = (output_action_a != timer16_pkg::ACT_OFF)
                       ? wave_q : port_value_a;
    assign pin_oe_a  = pin_direction_a;

    assign timer_count   = count_q;
    assign compare_a     = cmp_q;
    assign capture_value = cap_q;
    assign match_flag_a  = match_q;
    assign capture_flag  = capf_q;
    assign overflow_flag = ovf_q;
    assign wave_out_a    = wave_q;
endmodule : timer16_pwm

/* bench/timer16_pwm_properties.sv */
// Port-level checks for the timer waveform block
`timescale 1ns/1ps
module timer16_pwm_properties #(
    parameter int WIDTH = 16
) (
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic [2:0]       clock_select,
    input wire logic [3:0]       waveform_mode,
    input wire logic [1:0]       output_action_a,
    input wire logic             pin_direction_a,
    input wire logic             port_value_a,
    input wire logic [WIDTH-1:0] timer_count,
    input wire logic [WIDTH-1:0] compare_a,
    input wire logic [WIDTH-1:0] capture_value,
    input wire logic             match_flag_a,
    input wire logic             capture_flag,
    input wire logic             overflow_flag,
    input wire logic             wave_out_a,
    input wire logic             pin_out_a,
    input wire logic             pin_oe_a
);
    logic [1:0] live_q;
    logic       run;
    logic       cta;
    // Timing checks wait out the two-flop reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h3) begin
            live_q <= live_q + 2'h1;
        end
    end
    // Only the divide-by-one setting ticks on every clock
    assign run = live_q == 2'h3 && clock_select == timer16_pkg::PRE_1;
    assign cta = run && timer_count == compare_a;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_PIN_OE: assert property (pin_oe_a == pin_direction_a)
        else $error("pin enable differs from direction");
    AST_PORT_MUX: assert property (pin_out_a ==
        ((output_action_a != 2'h0) ? wave_out_a : port_value_a))
        else $error("pin source wrong");
    AST_CTC_CLEAR: assert property (cta && waveform_mode == 4'h4
        |=> timer_count == 16'h0000) else $error("no clear at top");
    AST_CAP_TOP: assert property (run &&
        (waveform_mode == 4'hc || waveform_mode == 4'he) &&
        timer_count == capture_value
        |=> capture_flag && timer_count == 16'h0000)
        else $error("capture top missed");
    AST_TOGGLE: assert property (cta && waveform_mode == 4'h4 &&
        output_action_a == 2'h1 |=> wave_out_a != $past(wave_out_a))
        else $error("no toggle on match");
    AST_MATCH: assert property (cta |=> match_flag_a)
        else $error("match flag not set");
    AST_FP_TOP: assert property (run && waveform_mode == 4'h5 &&
        timer_count == 16'h00ff |=> timer_count == 16'h0000 && overflow_flag)
        else $error("fixed top wrong");
    AST_FP_A_TOP: assert property (cta && waveform_mode == 4'hf
        |=> overflow_flag && match_flag_a && timer_count == 16'h0000)
        else $error("compare top wrong");
    AST_FP_UP: assert property (run && waveform_mode == 4'h7 &&
        timer_count != 16'h03ff |=> timer_count == $past(timer_count) + 1'b1)
        else $error("not counting up");
    AST_FP_HOLD: assert property (run && waveform_mode == 4'hf &&
        timer_count != compare_a |=> $stable(compare_a))
        else $error("compare changed off top");
endmodule : timer16_pwm_properties
bind timer16_pwm timer16_pwm_properties #(.WIDTH(WIDTH)) chk_i (.*);

/* bench/cpu_model.sv */
// Software side of the timer: register writes and flag clears
`timescale 1ns/1ps
module cpu_model (
    input  wire logic   clk,
    output logic        compare_a_we,
    output logic [15:0] compare_a_wdata,
    output logic        capture_we,
    output logic [15:0] capture_wdata,
    output logic [2:0]  flag_clr
);
    initial begin
        compare_a_we = 1'b0;
        capture_we = 1'b0;
        compare_a_wdata = 16'h0000;
        capture_wdata = 16'h0000;
        flag_clr = 3'h0;
    end
    // One-cycle strobe; data is scrambled once the strobe is gone
    task automatic wr(input logic top, input logic [15:0] d);
        logic [15:0] v;
        v = (top && d < 16'h0003) ? 16'h0003 : d;
        @(negedge clk);
        compare_a_we = !top;
        capture_we = top;
        compare_a_wdata = v;
        capture_wdata = v;
        @(negedge clk);
        compare_a_we = 1'b0;
        capture_we = 1'b0;
        compare_a_wdata = ~v;
        capture_wdata = ~v;
    endtask : wr
    // Clear pulses: bit 0 match, bit 1 capture, bit 2 overflow
    task automatic clr(input logic [2:0] m);
        @(negedge clk);
        flag_clr = m;
        @(negedge clk);
        flag_clr = 3'h0;
    endtask : clr
endmodule : cpu_model

/* bench/timer16_pwm_test.sv */
// Self-checking bench for the timer waveform block
`timescale 1ns/1ps
module timer16_pwm_test;
    logic clk, rstn, pin_direction_a, port_value_a, compare_a_we, capture_we;
    logic match_flag_a, capture_flag, overflow_flag, wave_out_a;
    logic pin_out_a, pin_oe_a;
    logic [2:0]  clock_select, flag_clr;
    logic [3:0]  waveform_mode;
    logic [1:0]  output_action_a;
    logic [15:0] compare_a_wdata, capture_wdata;
    logic [15:0] timer_count, compare_a, capture_value;
    int          failures, checked, hi, per;
    // Slow prescaler settings and their divide ratios
    logic [2:0]  div_sel[3] = '{3'h2, 3'h3, 3'h4};
    int          div_n[3] = '{8, 64, 256};
    // Row: mode, action, compare, top register, period, high cycles
    typedef struct {logic [3:0] m; logic [1:0] a;
        logic [15:0] c; logic [15:0] t; int p; int h;} row_t;
    row_t rows[9] = '{'{4'h4, 2'h1, 16'h0002, 16'h0000, 6, 3},
        '{4'h4, 2'h1, 16'h0000, 16'h0000, 2, 1},
        '{4'hf, 2'h1, 16'h0003, 16'h0000, 8, 4},
        '{4'he, 2'h2, 16'h0003, 16'h0009, 10, 6},
        '{4'he, 2'h3, 16'h0003, 16'h0009, 10, 4},
        '{4'he, 2'h3, 16'h0000, 16'h0009, 10, 1},
        '{4'h5, 2'h2, 16'h00f0, 16'h0000, 256, 15},
        '{4'h6, 2'h2, 16'h0100, 16'h0000, 512, 255},
        '{4'h7, 2'h3, 16'h0200, 16'h0000, 1024, 513}};
    timer16_pwm timer16_pwm_i (.*, .match_flag_a_clr(flag_clr[0]),
        .capture_flag_clr(flag_clr[1]), .overflow_flag_clr(flag_clr[2]));
    cpu_model cpu_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask : check
    // Reset with the counter stopped; state is checked while held
    task automatic restart();
        @(negedge clk);
        rstn = 1'b0;
        clock_select = 3'h0;
        waveform_mode = 4'h0;
        repeat (10) @(negedge clk);
        check("reset state", 0, |{timer_count, compare_a, capture_value,
              match_flag_a, capture_flag, overflow_flag, wave_out_a});
        rstn = 1'b1;
        repeat (3) @(negedge clk);
    endtask : restart
    // Bounded waits so a stuck output cannot hang the run
    task automatic wait_lvl(input logic v);
        for (int n = 0; wave_out_a !== v && n < 3000; n++) begin
            @(negedge clk);
            per++;
        end
    endtask : wait_lvl
    task automatic wait_count(input logic [15:0] v);
        for (int n = 0; timer_count !== v && n < 70000; n++) @(negedge clk);
    endtask : wait_count
    task automatic end_sim();
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Longest legal run is about 76k cycles
    initial begin
        #(90000 * 50);
        failures++;
        end_sim();
    end
    initial begin
        {rstn, clock_select, waveform_mode, output_action_a} = '0;
        {pin_direction_a, port_value_a, failures, checked} = '0;
        pin_direction_a = 1'b1;
        foreach (rows[i]) begin
            restart();
            cpu_model_i.wr(1'b0, rows[i].c);
            cpu_model_i.wr(1'b1, rows[i].t);
            waveform_mode = rows[i].m;
            output_action_a = rows[i].a;
            clock_select = 3'h1;
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            per = 0;
            wait_lvl(1'b0);
            hi = per;
            wait_lvl(1'b1);
            check("high time", rows[i].h, hi);
            check("period", rows[i].p, per);
        end
        // Buffered compare with fixed top masks the write
        restart();
        waveform_mode = 4'h5;
        clock_select = 3'h1;
        wait_count(16'h0020);
        cpu_model_i.wr(1'b0, 16'h12ab);
        check("compare held", 16'h0000, compare_a);
        wait_count(16'h0000);
        check("compare loaded", 16'h00ab, compare_a);
        // Register top: a mid-period write waits for top, no masking
        waveform_mode = 4'hf;
        wait_count(16'h0010);
        cpu_model_i.wr(1'b0, 16'h0140);
        check("top compare held", 16'h00ab, compare_a);
        wait_count(16'h0000);
        check("top compare loaded", 16'h0140, compare_a);
        // Mode 15 toggle through the slower prescaler settings
        for (int s = 0; s < 3; s++) begin
            restart();
            cpu_model_i.wr(1'b0, 16'h0003);
            waveform_mode = 4'hf;
            output_action_a = 2'h1;
            clock_select = div_sel[s];
            wait_lvl(1'b1);
            per = 0;
            wait_lvl(1'b0);
            hi = per;
            wait_lvl(1'b1);
            check("prescaled high", 4 * div_n[s], hi);
            check("prescaled period", 8 * div_n[s], per);
        end
        // Slowest prescaler: the count steps once in 1024 clocks
        restart();
        clock_select = 3'h5;
        wait_count(16'h0001);
        per = 0;
        while (timer_count === 16'h0001 && per < 3000) begin
            @(negedge clk);
            per++;
        end
        check("divide 1024", 1024, per);
        // Top lowered below the count: wraps through the maximum
        restart();
        waveform_mode = 4'hc;
        cpu_model_i.wr(1'b1, 16'h0064);
        clock_select = 3'h1;
        wait_count(16'h0032);
        cpu_model_i.wr(1'b1, 16'h000a);
        check("capture", 16'h000a, capture_value);
        cpu_model_i.clr(3'h7);
        wait_count(16'hffff);
        check("missed top", 0, capture_flag);
        @(negedge clk);
        check("wrap", 16'h0000, timer_count);
        check("overflow", 1, overflow_flag);
        // After the wrap the lowered top is matched
        wait_count(16'h000a);
        @(negedge clk);
        check("top after wrap", 1, capture_flag);
        check("clear at top", 16'h0000, timer_count);
        clock_select = 3'h0;
        cpu_model_i.clr(3'h7);
        check("cleared", 0, {match_flag_a, capture_flag, overflow_flag});
        // Port value reaches the pin while no action is selected
        output_action_a = 2'h0;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            {pin_direction_a, port_value_a} = k[1:0];
            @(posedge clk);
            check("pin value", k[0], pin_out_a);
            check("pin enable", k[1], pin_oe_a);
        end
        end_sim();
    end
endmodule : timer16_pwm_test
